// File: src/lms_lamps.sv
// Purpose: Front-panel lamp driver of a serial-link capture module.
// Assumes: Monitor inputs arrive asynchronously; APB zero-wait slave.
// Notes: Lamp word layout depends on the variant bit in the control register.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module lms_lamps #(
    parameter int MS_CYC = lms_pkg::MS_CYC,
    parameter int READY_MS = lms_pkg::READY_MS
) (
    input wire logic pclk, // Module clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB write.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire lms_pkg::lms_in_t mon_i, // Receiver and acquisition status.
    output logic ready_lamp, // Ready lamp.
    output logic host_access_lamp, // Host access lamp.
    output logic armed_lamp, // Armed lamp.
    output logic triggered_lamp, // Triggered lamp.
    output logic [31:0] panel_lamp, // Rate, status and activity lamps.
    output logic ready_fault // Power-on did not finish in time.
);
    // ------------------------------------------------------------
    // Input synchronisers and APB slave
    // ------------------------------------------------------------
    lms_pkg::lms_in_t in1_ff, in_s, in_d;
    logic [31:0] ctrl_ff, prdata_ff, panel_ff;
    logic [15:0] tmo_ff;
    logic pready_ff, pslverr_ff;
    logic setup, wr_en, mapped;
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready_ff && pwrite;
    assign mapped = paddr == lms_pkg::ADDR_CTRL || paddr == lms_pkg::ADDR_STAT
        || paddr == lms_pkg::ADDR_TMO;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in1_ff <= '0;
            in_s <= '0;
            in_d <= '0;
        end else begin
            in1_ff <= mon_i;
            in_s <= in1_ff;
            in_d <= in_s;
        end
    end

    // Answer is prepared in the setup cycle, so every access has no wait state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup && !mapped;
            if (setup) begin
                unique case (paddr)
                    lms_pkg::ADDR_CTRL: prdata_ff <= ctrl_ff;
                    lms_pkg::ADDR_STAT: prdata_ff <= panel_ff;
                    lms_pkg::ADDR_TMO: prdata_ff <= {16'h0000, tmo_ff};
                    default: prdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= lms_pkg::CTRL_RST;
            tmo_ff <= lms_pkg::TMO_RST;
        end else if (wr_en) begin
            if (paddr == lms_pkg::ADDR_CTRL)
                ctrl_ff <= pwdata & 32'h00000037;
            if (paddr == lms_pkg::ADDR_TMO)
                tmo_ff <= pwdata[15:0];
        end
    end

    logic lg, uni, swap;
    logic [1:0] wid;
    assign lg = ctrl_ff[lms_pkg::CTRL_LARGE];
    assign uni = ctrl_ff[lms_pkg::CTRL_UNI];
    assign swap = ctrl_ff[lms_pkg::CTRL_SWAP];
    assign wid = ctrl_ff[lms_pkg::CTRL_WID +: 2];

    // ------------------------------------------------------------
    // Millisecond tick and shared blink
    // ------------------------------------------------------------
    logic [15:0] ms_cnt_ff;
    logic tick, blink_ff;
    logic [7:0] blink_cnt_ff;
    assign tick = ms_cnt_ff == 16'(MS_CYC - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ms_cnt_ff <= 16'h0000;
        else
            ms_cnt_ff <= tick ? 16'h0000 : ms_cnt_ff + 16'h0001;
    end

    // A single divider keeps every blinking lamp in phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt_ff <= 8'h00;
            blink_ff <= 1'b0;
        end else if (tick) begin
            if (blink_cnt_ff == 8'(lms_pkg::BLINK_MS - 1)) begin
                blink_cnt_ff <= 8'h00;
                blink_ff <= !blink_ff;
            end else begin
                blink_cnt_ff <= blink_cnt_ff + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Ready, access, armed and triggered lamps
    // ------------------------------------------------------------
    logic [12:0] por_cnt_ff;
    logic [5:0] acc_cnt_ff;
    logic ready_ff, fault_ff, acc_ff, armed_ff, trig_ff;
    logic trig_rise, done_rise;
    assign trig_rise = in_s.trig && !in_d.trig;
    assign done_rise = in_s.acq_done && !in_d.acq_done;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_ff <= 1'b0;
            fault_ff <= 1'b0;
            por_cnt_ff <= 13'h0000;
        end else begin
            if (in_s.por_done)
                ready_ff <= 1'b1;
            if (tick && !ready_ff && por_cnt_ff != 13'(READY_MS))
                por_cnt_ff <= por_cnt_ff + 13'h0001;
            fault_ff <= !ready_ff && por_cnt_ff == 13'(READY_MS);
        end
    end

    // The lamp is stretched so a single bus cycle is visible to the eye.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_cnt_ff <= 6'h00;
            acc_ff <= 1'b0;
        end else begin
            if (setup)
                acc_cnt_ff <= 6'(lms_pkg::ACCESS_MS);
            else if (tick && acc_cnt_ff != 6'h00)
                acc_cnt_ff <= acc_cnt_ff - 6'h01;
            acc_ff <= acc_cnt_ff != 6'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_ff <= 1'b0;
            trig_ff <= 1'b0;
        end else begin
            armed_ff <= in_s.armed;
            if (trig_rise)
                trig_ff <= 1'b1;
            else if (done_rise)
                trig_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Link rate columns
    // ------------------------------------------------------------
    logic [1:0] rate_dn_ff, rate_up_ff;

    // Each rate code (down and up) is taken only after two equal samples, to mask a code in flight.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_dn_ff <= lms_pkg::RATE_NONE;
            rate_up_ff <= lms_pkg::RATE_NONE;
        end else begin
            if (in_s.rate_dn == in_d.rate_dn && in_s.rate_dn != lms_pkg::RATE_NONE)
                rate_dn_ff <= in_s.rate_dn;
            if (in_s.rate_up == in_d.rate_up && in_s.rate_up != lms_pkg::RATE_NONE)
                rate_up_ff <= in_s.rate_up;
        end
    end

    function automatic logic [2:0] rate_rows(input logic [1:0] r);
        rate_rows = {r == lms_pkg::RATE_8G0, r == lms_pkg::RATE_5G0, r == lms_pkg::RATE_2G5};
    endfunction

    function automatic logic [7:0] lane_mask(input logic [1:0] w);
        lane_mask = 8'((9'h002 << ((9'h001 << w) - 9'h001)) - 9'h001);
    endfunction

    // ------------------------------------------------------------
    // Per-lane idle timeout and activity
    // ------------------------------------------------------------
    logic [15:0] idle_cnt_ff [16];
    logic [15:0] act;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 16; i++)
                idle_cnt_ff[i] <= 16'h0000;
        end else begin
            for (int i = 0; i < 16; i++) begin
                if (!in_s.eidle[i] || in_s.sym_lock[i])
                    idle_cnt_ff[i] <= 16'h0000;
                else if (tick && idle_cnt_ff[i] < tmo_ff)
                    idle_cnt_ff[i] <= idle_cnt_ff[i] + 16'h0001;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (in_s.sym_lock[i])
                act[i] = 1'b1;
            else if (in_s.eidle[i])
                act[i] = idle_cnt_ff[i] < tmo_ff;
            else
                act[i] = blink_ff;
        end
    end

    // ------------------------------------------------------------
    // Acquisition progress
    // ------------------------------------------------------------
    lms_pkg::lms_prog_t pg_ff;
    logic [6:0] step_cnt_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pg_ff <= lms_pkg::PG_OFF;
            step_cnt_ff <= 7'h00;
        end else if (!in_s.run) begin
            pg_ff <= lms_pkg::PG_OFF;
            step_cnt_ff <= 7'h00;
        end else begin
            if (tick)
                step_cnt_ff <= step_cnt_ff + 7'h01;
            unique case (pg_ff)
                lms_pkg::PG_OFF: begin
                    pg_ff <= lms_pkg::PG_ROW3;
                    step_cnt_ff <= 7'h00;
                end
                lms_pkg::PG_ROW3: if (step_cnt_ff == 7'(lms_pkg::STEP_MS)) begin
                    pg_ff <= lms_pkg::PG_ROW4;
                end
                lms_pkg::PG_ROW4: if (in_s.deskewed) begin
                    pg_ff <= lms_pkg::PG_ROW5;
                end
                lms_pkg::PG_ROW5: if (!in_s.deskewed) begin
                    pg_ff <= lms_pkg::PG_ROW4;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Lamp word assembly
    // ------------------------------------------------------------
    logic [7:0] mdn, mup, adn, aup, ldn, lup, edn, eup;
    logic lk_dn, lk_up;
    logic [2:0] prog;
    logic [31:0] nxt_panel;

    always_comb begin
        mdn = lane_mask(lg ? wid : (wid > 2'h2 ? 2'h2 : wid));
        mup = mdn;
        adn = swap ? act[15:8] : act[7:0];
        aup = swap ? act[7:0] : act[15:8];
        ldn = swap ? in_s.sym_lock[15:8] : in_s.sym_lock[7:0];
        lup = swap ? in_s.sym_lock[7:0] : in_s.sym_lock[15:8];
        edn = swap ? in_s.eidle[15:8] : in_s.eidle[7:0];
        eup = swap ? in_s.eidle[7:0] : in_s.eidle[15:8];
        lk_dn = &((ldn | edn) | ~mdn);
        lk_up = &((lup | eup) | ~mup);
        if (uni) begin
            lk_dn = lk_dn && lk_up;
            lk_up = 1'b0;
        end
        if (lk_dn && &(edn | ~mdn) && (uni ? &(eup | ~mup) : 1'b1))
            lk_dn = blink_ff;
        if (lk_up && &(eup | ~mup))
            lk_up = blink_ff;
        unique case (pg_ff)
            lms_pkg::PG_OFF: prog = 3'h0;
            lms_pkg::PG_ROW3: prog = 3'h1;
            lms_pkg::PG_ROW4: prog = 3'h3;
            lms_pkg::PG_ROW5: prog = 3'h7;
        endcase
        nxt_panel = 32'h00000000;
        if (lg) begin
            nxt_panel[lms_pkg::L_RDN +: 3] = rate_rows(rate_dn_ff);
            nxt_panel[lms_pkg::L_RUP +: 3] = rate_rows(rate_up_ff);
            nxt_panel[lms_pkg::L_DIAG] = in_s.diag_pass;
            nxt_panel[lms_pkg::L_CLK] = in_s.clk_lock;
            nxt_panel[lms_pkg::L_LKDN] = lk_dn;
            nxt_panel[lms_pkg::L_LKUP] = lk_up;
            nxt_panel[lms_pkg::L_PROG +: 3] = prog;
            nxt_panel[lms_pkg::L_ACT +: 16] = {aup & mup, adn & mdn};
        end else begin
            nxt_panel[lms_pkg::L_RDN +: 3] = rate_rows(rate_dn_ff);
            nxt_panel[lms_pkg::S_DIAG] = in_s.diag_pass;
            nxt_panel[lms_pkg::S_CLK] = in_s.clk_lock;
            nxt_panel[lms_pkg::S_LKDN] = lk_dn;
            nxt_panel[lms_pkg::S_LKUP] = lk_up;
            nxt_panel[lms_pkg::S_ACT +: 8] = {aup[3:0] & mup[3:0], adn[3:0] & mdn[3:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            panel_ff <= 32'h00000000;
        else
            panel_ff <= nxt_panel;
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign ready_lamp = ready_ff;
    assign host_access_lamp = acc_ff;
    assign armed_lamp = armed_ff;
    assign triggered_lamp = trig_ff;
    assign panel_lamp = panel_ff;
    assign ready_fault = fault_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_hold_a: assert property (in_s.por_done |=> ready_lamp ##1 ready_lamp)
        else $error("ready lamp not steady after power-on");
    access_lamp_a: assert property (setup |=> ##1 host_access_lamp [*3])
        else $error("host access lamp missed an access");
    armed_follow_a: assert property (1 |=> armed_lamp == $past(in_s.armed))
        else $error("armed lamp does not follow armed state");
    trig_set_a: assert property (trig_rise |=> triggered_lamp)
        else $error("triggered lamp not set by trigger");
    trig_hold_a: assert property (triggered_lamp && !done_rise |=> triggered_lamp)
        else $error("triggered lamp dropped before acquisition end");
    rate_onehot_a: assert property (1 |=> $onehot0(panel_lamp[2:0]) && (!$past(lg) || $onehot0(panel_lamp[5:3])))
        else $error("more than one rate row lit");
    diag_dark_a: assert property (lg && !in_s.diag_pass |=> !panel_lamp[lms_pkg::L_DIAG])
        else $error("diagnostics lamp lit without pass");
    width_dark_a: assert property (lg && wid == 2'h2 |=> panel_lamp[23:20] == 4'h0)
        else $error("lanes beyond x4 not dark");
    small_count_a: assert property (!lg |=> panel_lamp[31:15] == 17'h00000)
        else $error("small variant drives more than 15 lamps");
    blink_step_a: assert property (!tick |=> $stable(blink_ff))
        else $error("blink changed outside a tick");
endmodule

// File: src/lms_pkg.sv
// Purpose: Constants and types for the link monitor status lamps.
// Assumes: 20 MHz module clock, APB register access.
// Notes: Times are in milliseconds; the block counts them in millisecond ticks.
package lms_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STAT = 12'h004;
    localparam logic [11:0] ADDR_TMO = 12'h008;
    localparam int CTRL_LARGE = 0;
    localparam int CTRL_UNI = 1;
    localparam int CTRL_SWAP = 2;
    localparam int CTRL_WID = 4;
    localparam logic [31:0] CTRL_RST = 32'h00000031;
    localparam logic [15:0] TMO_RST = 16'h03E8;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int MS_CYC = CLK_HZ / 1000;
    localparam int READY_MS = 5000;
    localparam int ACCESS_MS = 50;
    localparam int BLINK_MS = 250;
    localparam int STEP_MS = 100;
    // ------------------------------------------------------------
    // Lane rate codes and lamp positions
    // ------------------------------------------------------------
    localparam logic [1:0] RATE_NONE = 2'h0;
    localparam logic [1:0] RATE_2G5 = 2'h1;
    localparam logic [1:0] RATE_5G0 = 2'h2;
    localparam logic [1:0] RATE_8G0 = 2'h3;
    localparam int L_RDN = 0;
    localparam int L_RUP = 3;
    localparam int L_DIAG = 6;
    localparam int L_CLK = 7;
    localparam int L_LKDN = 8;
    localparam int L_LKUP = 9;
    localparam int L_PROG = 10;
    localparam int L_ACT = 16;
    localparam int S_DIAG = 3;
    localparam int S_CLK = 4;
    localparam int S_LKDN = 5;
    localparam int S_LKUP = 6;
    localparam int S_ACT = 7;
    typedef struct packed {
        logic [15:0] sym_lock;
        logic [15:0] eidle;
        logic [1:0] rate_dn;
        logic [1:0] rate_up;
        logic clk_lock;
        logic diag_pass;
        logic por_done;
        logic armed;
        logic trig;
        logic acq_done;
        logic run;
        logic deskewed;
    } lms_in_t;
    typedef enum logic [1:0] {
        PG_OFF = 2'b00,
        PG_ROW3 = 2'b01,
        PG_ROW4 = 2'b10,
        PG_ROW5 = 2'b11
    } lms_prog_t;
endpackage

// File: sim/lms_link_model.sv
// Purpose: Model of the observed link and acquisition state seen by the lamp block.
// Assumes: Commands change just after a rising edge of pclk.
// Notes: Status passes one flop, as a receiver status register would.
`timescale 1ns/1ps
module lms_link_model (
    input wire logic pclk, // Module clock.
    input wire logic presetn, // Reset, active low.
    input wire lms_pkg::lms_in_t cmd_i, // Wanted link state.
    output lms_pkg::lms_in_t mon_o // Status handed to the lamp block.
);
    // A real receiver never reports a lane idle and locked at once, so idle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon_o <= '0;
        end else begin
            mon_o <= cmd_i;
            mon_o.sym_lock <= cmd_i.sym_lock & ~cmd_i.eidle;
        end
    end
endmodule

// File: sim/testbench.sv
// Purpose: Self-checking bench for the status lamp block.
// Assumes: Millisecond tick shortened to 4 cycles, ready limit 20 ms.
// Notes: Blink phase is unknown, so blinking lamps are judged over a window.
`timescale 1ns/1ps
module testbench;
    localparam int MSC = 4;
    localparam int RDY = 20;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, pl;
    logic ready_lamp, host_access_lamp, armed_lamp, triggered_lamp, ready_fault;
    logic tog, same;
    logic [1:0] rate_q[$];
    logic [7:0] upl;
    lms_pkg::lms_in_t cmd, mon;
    int err_count, checked;

    initial begin
        pclk = 0;
        forever #25 pclk = ~pclk;
    end

    lms_link_model link (.pclk(pclk), .presetn(presetn), .cmd_i(cmd), .mon_o(mon));
    lms_lamps #(.MS_CYC(MSC), .READY_MS(RDY)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mon_i(mon), .ready_lamp(ready_lamp),
        .host_access_lamp(host_access_lamp), .armed_lamp(armed_lamp), .triggered_lamp(triggered_lamp),
        .panel_lamp(pl), .ready_fault(ready_fault));

    // ------------------------------------------------------------
    // Compare and bus tasks
    // ------------------------------------------------------------
    task cb(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task cl(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Ready, data and error are taken at the rising edge that closes the access.
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        cb("pready wait", 32'h1, 32'(n));
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wt(input int n);
        repeat (n) @(negedge pclk);
    endtask
    // Records whether lamp b toggles and whether lamp c always matches it while the upl lanes stay lit.
    task obs(input int n, input int b, input int c);
        logic s0, s1;
        s0 = 0;
        s1 = 0;
        same = 1;
        repeat (n) begin
            @(negedge pclk);
            s0 |= (pl[b] === 1'b0);
            s1 |= (pl[b] === 1'b1);
            same &= (pl[b] === pl[c]) && ((pl[31:24] & upl) === upl);
        end
        tog = s0 & s1;
    endtask
    function automatic logic [2:0] row(input logic [1:0] c);
        return (c == 2'h0) ? 3'h0 : 3'(3'h1 << (c - 2'h1));
    endfunction
    task summarize;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        err_count++;
        summarize();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = '0;
        pwdata = '0;
        cmd = '0;
        upl = '0;
        err_count = 0;
        checked = 0;
        void'($urandom(32'hfa25));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wt(1);
        cl("panel reset", 32'h0, pl);
        apb(1'b0, lms_pkg::ADDR_CTRL, 32'h0);
        cb("ctrl reset", lms_pkg::CTRL_RST, rd);
        apb(1'b0, lms_pkg::ADDR_TMO, 32'h0);
        cb("tmo reset", {16'h0, lms_pkg::TMO_RST}, rd);
        apb(1'b0, 12'h0FC, 32'h0);
        cb("unmapped err", 32'h1, 32'(er));
        cb("unmapped data", 32'h0, rd);
        apb(1'b1, lms_pkg::ADDR_STAT, 32'hFFFFFFFF);
        apb(1'b0, lms_pkg::ADDR_STAT, 32'h0);
        cb("stat read only", 32'h0, rd);
        wt(RDY * MSC + 10);
        cl("ready fault", 32'h1, 32'(ready_fault));
        cl("ready early", 32'h0, 32'(ready_lamp));
        @(posedge pclk) cmd.por_done <= 1'b1;
        wt(6);
        @(posedge pclk) cmd.por_done <= 1'b0;
        wt(6);
        cl("ready steady", 32'h1, 32'(ready_lamp));
        cl("fault cleared", 32'h0, 32'(ready_fault));
        wt(lms_pkg::ACCESS_MS * MSC + 20);
        cl("access idle", 32'h0, 32'(host_access_lamp));
        apb(1'b0, lms_pkg::ADDR_CTRL, 32'h0);
        wt(3);
        cl("access lit", 32'h1, 32'(host_access_lamp));
        wt(lms_pkg::ACCESS_MS * MSC + 20);
        cl("access off", 32'h0, 32'(host_access_lamp));
        @(posedge pclk) cmd.armed <= 1'b1;
        cmd.trig <= 1'b1;
        wt(6);
        cl("armed on", 32'h1, 32'(armed_lamp));
        @(posedge pclk) cmd.armed <= 1'b0;
        cmd.trig <= 1'b0;
        wt(6);
        cl("armed off", 32'h0, 32'(armed_lamp));
        cl("trig held", 32'h1, 32'(triggered_lamp));
        @(posedge pclk) cmd.acq_done <= 1'b1;
        wt(6);
        cl("trig end", 32'h0, 32'(triggered_lamp));
        rate_q = {2'h1, 2'h2, 2'h3, 2'($urandom_range(1, 3))};
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk) cmd.rate_dn <= rate_q[i];
            cmd.rate_up <= rate_q[(i + 1) % 4];
            cmd.diag_pass <= 1'($urandom_range(0, 1));
            cmd.clk_lock <= 1'($urandom_range(0, 1));
            wt(8);
            cl("rate down", 32'(row(rate_q[i])), 32'(pl[2:0]));
            cl("rate up", 32'(row(rate_q[(i + 1) % 4])), 32'(pl[5:3]));
            cl("diag", 32'(cmd.diag_pass), 32'(pl[6]));
            cl("clock found", 32'(cmd.clk_lock), 32'(pl[7]));
        end
        @(posedge pclk) cmd.rate_dn <= 2'h0;
        wt(6);
        cl("rate held", 32'(row(rate_q[3])), 32'(pl[2:0]));
        upl = 8'($urandom) & 8'hFE;
        @(posedge pclk) cmd.sym_lock <= {upl, 8'h00};
        cmd.eidle <= 16'h00FF;
        wt(6);
        obs(2200, lms_pkg::L_LKDN, lms_pkg::L_ACT + 8);
        cl("idle link blinks", 32'h1, 32'(tog));
        cl("blink in phase", 32'h1, 32'(same));
        cl("idle lanes lit", 32'hFF, 32'(pl[23:16]));
        cl("up lock off", 32'h0, 32'(pl[9]));
        apb(1'b1, lms_pkg::ADDR_TMO, 32'h0000000A);
        wt(6);
        cl("idle lanes timed out", 32'h0, 32'(pl[23:16]));
        @(posedge pclk) cmd.sym_lock <= 16'hFFFF;
        cmd.eidle <= 16'h0000;
        upl = 8'h00;
        wt(6);
        cl("all lanes", 32'hFFFF, 32'(pl[31:16]));
        cl("link locks", 32'h3, 32'(pl[9:8]));
        apb(1'b1, lms_pkg::ADDR_CTRL, 32'h35);
        @(posedge pclk) cmd.eidle <= 16'h00FF;
        wt(6);
        obs(1100, lms_pkg::L_LKUP, lms_pkg::L_LKUP);
        cl("swap up blinks", 32'h1, 32'(tog));
        cl("swap down steady", 32'h1, 32'(pl[8]));
        @(posedge pclk) cmd.eidle <= 16'h0000;
        apb(1'b1, lms_pkg::ADDR_CTRL, 32'h33);
        wt(6);
        cl("uni locks", 32'h1, 32'(pl[9:8]));
        apb(1'b1, lms_pkg::ADDR_CTRL, 32'h21);
        wt(6);
        cl("x4 lanes", 32'h0F0F, 32'(pl[31:16]));
        apb(1'b1, lms_pkg::ADDR_CTRL, 32'h30);
        wt(6);
        cl("small word", 32'h7FE0 | 32'(row(rate_q[3])) | 32'(cmd.diag_pass) << 3
            | 32'(cmd.clk_lock) << 4, pl);
        apb(1'b1, lms_pkg::ADDR_CTRL, 32'h31);
        @(posedge pclk) cmd.run <= 1'b1;
        wt(6);
        cl("row three", 32'h1, 32'(pl[10]));
        wt(lms_pkg::STEP_MS * MSC + 20);
        cl("row four", 32'h1, 32'(pl[11]));
        @(posedge pclk) cmd.deskewed <= 1'b1;
        wt(6);
        cl("row five", 32'h1, 32'(pl[12]));
        @(posedge pclk) cmd.run <= 1'b0;
        wt(6);
        cl("rows clear", 32'h0, 32'(pl[12:10]));
        summarize();
    end
endmodule
